// *** rtl/usb_config_register_one.sv ***
// Contract
// - Eye test field set drives continuous eye pattern on D+/D-.
// - Monitor field set: monitor output follows line drive intervals.
// - Monitor is inert unless internal transceiver disable is active.
// - Stop-in-idle set halts module while chip idle; else runs on.
// - Ping-pong 11 pairs endpoints 1-15; 10 pairs every endpoint.
// - Ping-pong 01 pairs endpoint 0 receive only; 00 disables pairs.
// - Bits 15-8, 5, 3, 2 ignore writes and read zero.
// - Implemented fields are read/write and reset to zero.
`timescale 1ns/10ps
`include "usb_cfg_one_defines.svh"

module usb_config_register_one (
    input  wire logic        CORE_CLK,
    input  wire logic        NRST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             WB_ERR_O,
    input  wire logic        INTERNAL_TRANSCEIVER_DISABLE,
    input  wire logic        LINE_DRIVE_ACTIVE,
    input  wire logic        CHIP_IDLE,
    output logic             EYE_DP_OUT,
    output logic             EYE_DM_OUT,
    output logic             EYE_TEST_ACTIVE,
    output logic             OE_MONITOR_N,
    output logic             MODULE_HALT,
    output logic             PPB_EP0_RX_EN,
    output logic             PPB_EP0_TX_EN,
    output logic             PPB_EP1_15_EN
);
    typedef struct packed {
        logic [15:0] cfg_r;
        logic        ack_r;
        logic        err_r;
        logic [31:0] rdat_r;
        logic        trdis_s1_r;
        logic        trdis_s2_r;
        logic        drv_s1_r;
        logic        drv_s2_r;
        logic        idle_s1_r;
        logic        idle_s2_r;
        logic        mon_n_r;
        logic        halt_r;
        logic        ep0_rx_r;
        logic        ep0_tx_r;
        logic        ep1_15_r;
    } cfg_state_type;

    cfg_state_type st_r;
    cfg_state_type st_nxt;
    logic          eye_dp;
    logic          eye_dm;

    function automatic logic [2:0] ppb_decode(input logic [1:0] m);
        // Returns {ep1_15, ep0_tx, ep0_rx}
        case (usb_cfg_one_pkg::ppb_mode_type'(m))
            usb_cfg_one_pkg::PPB_EP1_15: ppb_decode = 3'h4;
            usb_cfg_one_pkg::PPB_ALL:    ppb_decode = 3'h7;
            usb_cfg_one_pkg::PPB_EP0_RX: ppb_decode = 3'h1;
            usb_cfg_one_pkg::PPB_NONE:   ppb_decode = 3'h0;
            default:                     ppb_decode = 3'h0;
        endcase
    endfunction

    logic       req;
    logic       hit;
    logic [2:0] ppb_v;

    always_comb begin
        st_nxt = st_r;
        req = WB_CYC_I && WB_STB_I && !st_r.ack_r && !st_r.err_r;
        hit = (WB_ADR_I == `CFG_ONE_ADDR);
        ppb_v = ppb_decode(st_r.cfg_r[`FLD_PPB_HI:`FLD_PPB_LO]);
        // Pins are slow; two flops before use
        st_nxt.trdis_s1_r = INTERNAL_TRANSCEIVER_DISABLE;
        st_nxt.trdis_s2_r = st_r.trdis_s1_r;
        st_nxt.drv_s1_r   = LINE_DRIVE_ACTIVE;
        st_nxt.drv_s2_r   = st_r.drv_s1_r;
        st_nxt.idle_s1_r  = CHIP_IDLE;
        st_nxt.idle_s2_r  = st_r.idle_s1_r;
        st_nxt.ack_r  = req && hit;
        st_nxt.err_r  = req && !hit;
        st_nxt.rdat_r = 32'h0;
        if (req && hit) begin
            if (WB_WE_I) begin
                if (WB_SEL_I[0]) begin
                    // Mask cut to the one written lane
                    st_nxt.cfg_r[7:0] = WB_DAT_I[7:0]
                                        & 8'(`CFG_ONE_WMASK);
                end
            end else begin
                st_nxt.rdat_r = {16'h0, st_r.cfg_r & `CFG_ONE_WMASK};
            end
        end
        // Active-low monitor, only with external transceiver in use
        st_nxt.mon_n_r = !(st_r.cfg_r[`FLD_OEMON] && st_r.trdis_s2_r
                           && st_r.drv_s2_r);
        st_nxt.halt_r   = st_r.cfg_r[`FLD_SIDL] && st_r.idle_s2_r;
        st_nxt.ep1_15_r = ppb_v[2];
        st_nxt.ep0_tx_r = ppb_v[1];
        st_nxt.ep0_rx_r = ppb_v[0];
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_r         <= '0;
            st_r.cfg_r   <= `CFG_ONE_RESET;
            st_r.mon_n_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pattern generator restarts cleanly each time the test is enabled
    eye_pattern_gen u_eye (
        .CORE_CLK (CORE_CLK),
        .NRST     (NRST),
        .enable   (st_r.cfg_r[`FLD_EYE]),
        .dp_out   (eye_dp),
        .dm_out   (eye_dm)
    );

    logic eye_act_r;
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            eye_act_r <= 1'b0;
        end else begin
            eye_act_r <= st_r.cfg_r[`FLD_EYE];
        end
    end

    assign WB_DAT_O        = st_r.rdat_r;
    assign WB_ACK_O        = st_r.ack_r;
    assign WB_ERR_O        = st_r.err_r;
    assign EYE_DP_OUT      = eye_dp;
    assign EYE_DM_OUT      = eye_dm;
    assign EYE_TEST_ACTIVE = eye_act_r;
    assign OE_MONITOR_N    = st_r.mon_n_r;
    assign MODULE_HALT     = st_r.halt_r;
    assign PPB_EP0_RX_EN   = st_r.ep0_rx_r;
    assign PPB_EP0_TX_EN   = st_r.ep0_tx_r;
    assign PPB_EP1_15_EN   = st_r.ep1_15_r;

    AST_RESERVED_ZERO: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (st_r.cfg_r & ~`CFG_ONE_WMASK) == 16'h0)
        else $error("Reserved config bits not zero");
    AST_RD_RESERVED: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0 && !WB_DAT_O[5]
        && WB_DAT_O[3:2] == 2'h0)
        else $error("Read shows reserved bits");
    AST_WRITE_TAKES: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && !WB_ACK_O
         && !WB_ERR_O && WB_ADR_I == `CFG_ONE_ADDR)
        |=> st_r.cfg_r[7:0] == ($past(WB_DAT_I[7:0]) & 8'hd3))
        else $error("Write not stored");
    AST_ACK_PULSE: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("Ack longer than a cycle");
    AST_MON_INERT: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !st_r.trdis_s2_r |=> OE_MONITOR_N)
        else $error("Monitor active without external transceiver");
    AST_MON_DRIVE: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (st_r.cfg_r[6] && st_r.trdis_s2_r && st_r.drv_s2_r)
        |=> !OE_MONITOR_N)
        else $error("Monitor not asserted while driving");
    AST_HALT: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        ##1 MODULE_HALT == $past(st_r.cfg_r[4] && st_r.idle_s2_r))
        else $error("Halt does not follow idle and stop bit");
    AST_PPB_EP1: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (st_r.cfg_r[1:0] == 2'h3) |=> PPB_EP1_15_EN && !PPB_EP0_RX_EN)
        else $error("Mode 11 pairing wrong");
    AST_PPB_EP0: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (st_r.cfg_r[1:0] == 2'h1) |=> PPB_EP0_RX_EN && !PPB_EP0_TX_EN
        && !PPB_EP1_15_EN)
        else $error("Mode 01 pairing wrong");
    AST_EYE: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        st_r.cfg_r[7] [*3] |-> EYE_DP_OUT != EYE_DM_OUT)
        else $error("Eye pattern lines not differential");

    COV_WRITE: cover property (@(posedge CORE_CLK) WB_ACK_O && WB_WE_I);
    COV_ALL: cover property (@(posedge CORE_CLK) PPB_EP0_TX_EN);
    COV_MON: cover property (@(posedge CORE_CLK) !OE_MONITOR_N);
    COV_HALT: cover property (@(posedge CORE_CLK) MODULE_HALT);
endmodule

// *** rtl/usb_cfg_one_defines.svh ***
`ifndef USB_CFG_ONE_DEFINES_SVH
`define USB_CFG_ONE_DEFINES_SVH

`define CFG_ONE_ADDR       4'h0
`define CFG_ONE_RESET      16'h0000
`define CFG_ONE_WMASK      16'h00d3
`define FLD_EYE            7
`define FLD_OEMON          6
`define FLD_SIDL           4
`define FLD_PPB_HI         1
`define FLD_PPB_LO         0
`define EYE_PAT_BITS       8'h80
`define EYE_PAT_RESET      8'h00

`endif

// *** rtl/usb_cfg_one_pkg.sv ***
package usb_cfg_one_pkg;
    typedef enum logic [1:0] {
        PPB_NONE    = 2'h0,
        PPB_EP0_RX  = 2'h1,
        PPB_ALL     = 2'h2,
        PPB_EP1_15  = 2'h3
    } ppb_mode_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1
    } bus_state_type;
endpackage

// *** rtl/eye_pattern_gen.sv ***
`timescale 1ns/10ps
`include "usb_cfg_one_defines.svh"

module eye_pattern_gen (
    input  wire logic CORE_CLK,
    input  wire logic NRST,
    input  wire logic enable,
    output logic      dp_out,
    output logic      dm_out
);
    typedef struct packed {
        logic [7:0] shift_r;
        logic       dp_r;
        logic       dm_r;
    } eye_state_type;

    eye_state_type st_r;
    eye_state_type st_nxt;

    // Repeating J/K pattern; restarts from seed whenever the test is off
    always_comb begin
        st_nxt = st_r;
        if (enable) begin
            st_nxt.shift_r = {st_r.shift_r[6:0], ~st_r.shift_r[7]};
            st_nxt.dp_r    = st_r.shift_r[7];
            st_nxt.dm_r    = ~st_r.shift_r[7];
        end else begin
            st_nxt.shift_r = `EYE_PAT_BITS;
            st_nxt.dp_r    = 1'b0;
            st_nxt.dm_r    = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= '{shift_r: `EYE_PAT_RESET, dp_r: 1'b0, dm_r: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dp_out = st_r.dp_r;
    assign dm_out = st_r.dm_r;
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic        CORE_CLK, NRST, cyc, stb, we, trdis, drive, idle;
    logic        ack, err, dp, dm, eye, mon_n, halt, rx0, tx0, ep15;
    logic        err_seen;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, got;
    int          fail_count, check_count;

    usb_config_register_one dut (
        .CORE_CLK(CORE_CLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err),
        .INTERNAL_TRANSCEIVER_DISABLE(trdis), .LINE_DRIVE_ACTIVE(drive),
        .CHIP_IDLE(idle), .EYE_DP_OUT(dp), .EYE_DM_OUT(dm),
        .EYE_TEST_ACTIVE(eye), .OE_MONITOR_N(mon_n), .MODULE_HALT(halt),
        .PPB_EP0_RX_EN(rx0), .PPB_EP0_TX_EN(tx0), .PPB_EP1_15_EN(ep15)
    );

    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] seen);
        check_count++;
        if (exp !== seen) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Request held until ack or err is sampled, then released at that edge
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n = 0;
        @(posedge CORE_CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        got = rdat;
        err_seen = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            results();
        end
    endtask

    // Covers the two input sync flops plus the output register
    task automatic settle();
        repeat (4) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask

    task automatic pins(input logic t, input logic d, input logic i);
        @(posedge CORE_CLK);
        trdis <= t;
        drive <= d;
        idle <= i;
    endtask

    task automatic reset_state();
        wb(1'b0, 4'h0, 4'hf, 32'h0);
        chk("reset read", 32'h0, got);
        @(negedge CORE_CLK);
        chk("reset outs", 32'h40,
            {eye, mon_n, halt, rx0, tx0, ep15, dp, dm});
    endtask

    task automatic masks();
        wb(1'b1, 4'h0, 4'hf, 32'hffff_ffff);
        wb(1'b0, 4'h0, 4'hf, 32'h0);
        chk("masked read", 32'hd3, got);
        wb(1'b1, 4'h0, 4'he, 32'h0);
        wb(1'b0, 4'h0, 4'hf, 32'h0);
        chk("lane0 off", 32'hd3, got);
        wb(1'b1, 4'h3, 4'hf, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err_seen});
        wb(1'b0, 4'h0, 4'hf, 32'h0);
        chk("unmapped kept", 32'hd3, got);
    endtask

    task automatic ppb_modes();
        logic [2:0] exp [4] = '{3'b000, 3'b100, 3'b111, 3'b001};
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, 4'h0, 4'h1, 32'(m));
            settle();
            chk("ppb enables", {29'h0, exp[m]},
                {29'h0, rx0, tx0, ep15});
        end
    endtask

    task automatic monitor();
        pins(1'b1, 1'b1, 1'b0);
        wb(1'b1, 4'h0, 4'h1, 32'h40);
        settle();
        chk("mon driving", 32'h0, {31'h0, mon_n});
        pins(1'b1, 1'b0, 1'b0);
        settle();
        chk("mon released", 32'h1, {31'h0, mon_n});
        pins(1'b0, 1'b1, 1'b0);
        settle();
        chk("mon internal", 32'h1, {31'h0, mon_n});
    endtask

    task automatic idle_stop();
        pins(1'b1, 1'b1, 1'b1);
        wb(1'b1, 4'h0, 4'h1, 32'h10);
        settle();
        chk("halt set", 32'h3, {30'h0, mon_n, halt});
        wb(1'b1, 4'h0, 4'h1, 32'h0);
        settle();
        chk("halt clear", 32'h2, {30'h0, mon_n, halt});
    endtask

    task automatic eye_test();
        logic a;
        int   n;
        wb(1'b1, 4'h0, 4'h1, 32'h80);
        settle();
        a = dp;
        chk("eye flag", 32'h1, {31'h0, eye});
        chk("eye pair", {31'h0, ~a}, {31'h0, dm});
        // Pattern toggles every 8 cycles; a level change must come within a period
        n = 0;
        do begin
            @(negedge CORE_CLK);
            n++;
        end while (dp === a && n < 16);
        chk("eye toggle", {31'h0, ~a}, {31'h0, dp});
        chk("eye pair moving", {31'h0, ~dp}, {31'h0, dm});
        wb(1'b1, 4'h0, 4'h1, 32'h0);
        settle();
        chk("eye off", 32'h0, {30'h0, dp, dm});
    endtask

    initial begin
        NRST = 1'b0;
        {cyc, stb, we, trdis, drive, idle} = 6'h0;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h0;
        fail_count = 0;
        check_count = 0;
        repeat (12) @(posedge CORE_CLK);
        NRST <= 1'b1;
        reset_state();
        masks();
        ppb_modes();
        monitor();
        idle_stop();
        eye_test();
        results();
    end
endmodule
